// >>> core/pwm_pkg.sv
// Shared constants for the single-channel waveform core and its register bus
package pwm_pkg;

  // Register bus geometry
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;

  // Byte addresses of the registers
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] DUTY_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] ACT_PERIOD_OFS = 8'h14;
  localparam logic [7:0] ACT_DUTY_OFS = 8'h18;

  // Control register field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_LEVEL_BIT = 1;
  localparam int unsigned CTRL_CENTER_BIT = 2;

  // Status register field positions
  localparam int unsigned STAT_LEVEL_BIT = 0;
  localparam int unsigned STAT_DOWN_BIT = 1;

  // Values after reset
  localparam logic RUN_RST = 1'b0;
  localparam logic LEVEL_RST = 1'b0;
  localparam logic CENTER_RST = 1'b0;
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // State of the edge-synchronised clock gate
  typedef struct packed {
    logic open;
    logic tick;
  } gate_state_t;

endpackage : pwm_pkg

// >>> core/pwm_tick_gate.sv
// Edge-synchronised gate between the selected clock tick and the channel counter
`timescale 1ns/1ps
`default_nettype none

module pwm_tick_gate (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sel_tick,
  input wire logic channel_run_enable,
  output var logic gated_tick
);

  pwm_pkg::gate_state_t s_q;
  pwm_pkg::gate_state_t s_d;

  // Gate opens or closes only on a tick edge, so no runt tick leaks through
  always_comb begin
    s_d = s_q;
    if (sel_tick) begin
      s_d.open = channel_run_enable;
    end
    s_d.tick = sel_tick && s_q.open && channel_run_enable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign gated_tick = s_q.tick;

  // A gated tick always stems from a tick seen through an open gate
  a_gate_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    gated_tick |-> $past(sel_tick) && $past(s_q.open))
    else $error("gated tick without an open gate");

endmodule : pwm_tick_gate

`default_nettype wire

// >>> core/pwm_channel_waveform_core.sv
// One waveform channel: counter, double-buffered period and duty, AXI4-Lite registers
//
// Functional notes
// - Selected clock reaches the channel only while enabled, gated at tick edges.
// - Counter holds still and never counts while the channel is disabled.
// - Polarity set: output starts high, drops low on duty match.
// - Polarity clear: output starts low, rises high on duty match.
// - Period and duty buffered; take effect at period end, counter write, disable.
// - Any counter write clears the counter to zero, value ignored.
// - While disabled, period and duty writes reach active latches at once.
// - Counter write reloads buffered period and duty immediately; one odd cycle possible.
// - Software may read the live counter value at any time.
// - Duty holds high time or low time depending on polarity.
// - Channel owns an 8-bit up/down counter advancing at selected clock rate.
// - Counter equal to active duty flips the output level.
// - Period match handling depends on left or center aligned mode.
`timescale 1ns/1ps
`default_nettype none

module pwm_channel_waveform_core #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sel_tick,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [pwm_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output var logic wready,
  input wire logic [pwm_pkg::AXI_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output var logic bvalid,
  input wire logic bready,
  output var logic [1:0] bresp,
  input wire logic arvalid,
  output var logic arready,
  input wire logic [pwm_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output var logic rvalid,
  input wire logic rready,
  output var logic [pwm_pkg::AXI_DATA_W-1:0] rdata,
  output var logic [1:0] rresp,
  output var logic pwm_out
);

  // Counter must fit the 32-bit data word and need at least two bits
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 2 and 32");
  end

  typedef logic [CNT_W-1:0] cnt_t;

  typedef struct packed {
    logic run;
    logic start_level;
    logic center;
    cnt_t per_buf;
    cnt_t duty_buf;
    cnt_t per_act;
    cnt_t duty_act;
    cnt_t cnt;
    logic dir_down;
    logic level;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [pwm_pkg::AXI_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic gated_tick;
  logic wr_fire;
  logic cnt_wr;
  logic per_end;
  logic [CNT_W:0] cnt_inc;

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Read decode; unmapped words answer zero
  function automatic logic [31:0] read_word(input state_t s,
                                            input logic [pwm_pkg::AXI_ADDR_W-1:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case ({a[pwm_pkg::AXI_ADDR_W-1:2], 2'b00})
      pwm_pkg::CTRL_OFS: begin
        r[pwm_pkg::CTRL_RUN_BIT] = s.run;
        r[pwm_pkg::CTRL_LEVEL_BIT] = s.start_level;
        r[pwm_pkg::CTRL_CENTER_BIT] = s.center;
      end
      pwm_pkg::PERIOD_OFS: r = 32'(s.per_buf);
      pwm_pkg::DUTY_OFS: r = 32'(s.duty_buf);
      pwm_pkg::COUNT_OFS: r = 32'(s.cnt);
      pwm_pkg::STATUS_OFS: begin
        r[pwm_pkg::STAT_LEVEL_BIT] = s.level;
        r[pwm_pkg::STAT_DOWN_BIT] = s.dir_down;
      end
      pwm_pkg::ACT_PERIOD_OFS: r = 32'(s.per_act);
      pwm_pkg::ACT_DUTY_OFS: r = 32'(s.duty_act);
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_word

  function automatic logic mapped(input logic [pwm_pkg::AXI_ADDR_W-1:0] a);
    logic [pwm_pkg::AXI_ADDR_W-1:0] w;
    w = {a[pwm_pkg::AXI_ADDR_W-1:2], 2'b00};
    return w <= pwm_pkg::ACT_DUTY_OFS;
  endfunction : mapped

  pwm_tick_gate u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel_tick(sel_tick),
    .channel_run_enable(s_q.run),
    .gated_tick(gated_tick)
  );

  // Next-state logic: bus slave first, then the waveform counter
  always_comb begin
    s_d = s_q;
    cnt_wr = 1'b0;
    per_end = 1'b0;
    cnt_inc = {1'b0, s_q.cnt} + {{CNT_W{1'b0}}, 1'b1};

    // Address and data are taken independently, in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.waddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.waddr) ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
      unique case ({s_q.waddr[pwm_pkg::AXI_ADDR_W-1:2], 2'b00})
        pwm_pkg::CTRL_OFS: begin
          if (s_q.wstrb[0]) begin
            s_d.run = s_q.wdata[pwm_pkg::CTRL_RUN_BIT];
            s_d.start_level = s_q.wdata[pwm_pkg::CTRL_LEVEL_BIT];
            s_d.center = s_q.wdata[pwm_pkg::CTRL_CENTER_BIT];
          end
        end
        pwm_pkg::PERIOD_OFS: begin
          s_d.per_buf = CNT_W'(merge(32'(s_q.per_buf), s_q.wdata, s_q.wstrb));
        end
        pwm_pkg::DUTY_OFS: begin
          s_d.duty_buf = CNT_W'(merge(32'(s_q.duty_buf), s_q.wdata, s_q.wstrb));
        end
        pwm_pkg::COUNT_OFS: cnt_wr = 1'b1;
        default: begin
        end
      endcase
    end
    // Each ready only while its own channel holds nothing and no response waits, so one write is under way at a time
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready = !s_d.w_held && !s_d.bvalid;

    // Read channel: one read in flight, data sampled at the address handshake
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = read_word(s_q, araddr);
      s_d.rresp = mapped(araddr) ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;

    // Waveform counter; counter write wins over a tick in the same cycle
    if (cnt_wr) begin
      s_d.cnt = '0;
      s_d.dir_down = 1'b0;
      s_d.per_act = s_d.per_buf;
      s_d.duty_act = s_d.duty_buf;
    end else if (s_q.run && gated_tick) begin
      if (!s_q.center) begin
        if (cnt_inc >= {1'b0, s_q.per_act}) begin
          s_d.cnt = '0;
          per_end = 1'b1;
        end else begin
          s_d.cnt = cnt_inc[CNT_W-1:0];
        end
      end else if (!s_q.dir_down) begin
        // Overshoot after a disabled rewrite is clipped to the period
        if (cnt_inc >= {1'b0, s_q.per_act}) begin
          s_d.cnt = s_q.per_act;
          s_d.dir_down = 1'b1;
        end else begin
          s_d.cnt = cnt_inc[CNT_W-1:0];
        end
      end else begin
        if (s_q.cnt <= cnt_t'(1)) begin
          s_d.cnt = '0;
          s_d.dir_down = 1'b0;
          per_end = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - cnt_t'(1);
        end
      end
      if (per_end) begin
        s_d.per_act = s_q.per_buf;
        s_d.duty_act = s_q.duty_buf;
      end
    end

    // Disabled channel: buffers pass straight into the active latches
    if (!s_q.run) begin
      s_d.per_act = s_d.per_buf;
      s_d.duty_act = s_d.duty_buf;
    end

    // Level below duty is the start level; crossing the duty flips it
    s_d.level = (s_d.cnt < s_d.duty_act) ? s_d.start_level : !s_d.start_level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.run <= pwm_pkg::RUN_RST;
      s_q.start_level <= pwm_pkg::LEVEL_RST;
      s_q.center <= pwm_pkg::CENTER_RST;
      s_q.per_buf <= cnt_t'(pwm_pkg::PERIOD_RST);
      s_q.duty_buf <= cnt_t'(pwm_pkg::DUTY_RST);
      s_q.per_act <= cnt_t'(pwm_pkg::PERIOD_RST);
      s_q.duty_act <= cnt_t'(pwm_pkg::DUTY_RST);
      // Level that the reset count shows, so no false edge follows reset
      s_q.level <= (pwm_pkg::DUTY_RST == 8'h00) ? !pwm_pkg::LEVEL_RST : pwm_pkg::LEVEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // All outputs are state flip-flops
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign pwm_out = s_q.level;

  // Disabled channel never moves its counter except by a software write
  a_cnt_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s_q.run && !cnt_wr) |=> $stable(s_q.cnt))
    else $error("counter moved while disabled");

  // Counter write always lands on zero
  a_cnt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_wr |=> (s_q.cnt == '0) && !s_q.dir_down)
    else $error("counter write did not clear the counter");

  // Counter write forces the buffered values live
  a_wr_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_wr |=> (s_q.per_act == s_q.per_buf) && (s_q.duty_act == s_q.duty_buf))
    else $error("counter write did not reload active values");

  // Disabled channel loads its buffers into the active latches at the same edge
  a_disabled_direct: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_q.run |=> (s_q.per_act == $past(s_d.per_buf)) && (s_q.duty_act == $past(s_d.duty_buf)))
    else $error("disabled write not placed in active latches");

  // Running channel keeps old values until period end or counter write
  a_defer_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.run && !cnt_wr && !per_end) |=> $stable(s_q.per_act) && $stable(s_q.duty_act))
    else $error("active value changed mid period");

  // Output level follows count against duty and polarity
  a_level_map: assert property (@(posedge aclk) disable iff (!aresetn)
    pwm_out == ((s_q.cnt < s_q.duty_act) ? s_q.start_level : !s_q.start_level))
    else $error("output level inconsistent with count and duty");

  // Left aligned wrap returns to zero and start level when duty is nonzero
  a_left_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.run && gated_tick && !cnt_wr && !s_q.center && cnt_inc >= {1'b0, s_q.per_act})
    |=> (s_q.cnt == '0) && (s_q.duty_act == '0 || pwm_out == s_q.start_level))
    else $error("left aligned period match did not restart the cycle");

  // Center aligned reaches the period and then turns down
  a_center_turn: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.run && gated_tick && !cnt_wr && s_q.center && !s_q.dir_down &&
     cnt_inc >= {1'b0, s_q.per_act}) |=> s_q.dir_down && (s_q.cnt == $past(s_q.per_act)))
    else $error("center aligned count did not turn at the period");

  // Write response holds until accepted
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");

  // Read data and response hold until rready
  a_rd_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped before rready");

  // No new write taken while a response waits
  a_wr_single: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid |-> !awready && !wready)
    else $error("write channel ready during pending response");

  // Counter moves only on a gated tick or a software write
  a_tick_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (!gated_tick && !cnt_wr) |=> $stable(s_q.cnt))
    else $error("counter moved without a tick");

  // Center aligned count turns up again at zero
  a_center_floor: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.run && gated_tick && !cnt_wr && s_q.center && s_q.dir_down &&
     s_q.cnt <= cnt_t'(1)) |=> (s_q.cnt == '0) && !s_q.dir_down)
    else $error("center aligned count did not turn at zero");

  // Period end takes the buffered values live
  a_period_load: assert property (@(posedge aclk) disable iff (!aresetn)
    per_end |=> (s_q.per_act == $past(s_q.per_buf)) &&
    (s_q.duty_act == $past(s_q.duty_buf)))
    else $error("buffered values not loaded at period end");

endmodule : pwm_channel_waveform_core

`default_nettype wire

// >>> verif/pwm_load.sv
// Load model on the waveform pin: measures the last high and low run lengths
`timescale 1ns/1ps
`default_nettype none

module pwm_load (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pwm_out,
  output logic [15:0] high_len,
  output logic [15:0] low_len
);
  logic prev_q;
  logic [15:0] run_q;

  // Run length closes on each level change; a load sees only whole runs
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= pwm_out; // Follow the pin in reset, so release shows no false edge
      run_q <= 16'h0001;
      high_len <= 16'h0000;
      low_len <= 16'h0000;
    end else if (pwm_out === prev_q) begin
      run_q <= run_q + 16'h0001;
    end else begin
      if (prev_q) high_len <= run_q;
      else low_len <= run_q;
      prev_q <= pwm_out;
      run_q <= 16'h0001;
    end
  end
endmodule : pwm_load
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench: register bus tasks, table of register cases, waveform tests
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("Error %0t: got %h exp %h", $time, (a), (e)); end end

module testbench;
  logic aclk, aresetn, sel_tick;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pwm_out;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, c1, c2;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] high_len, low_len;
  int failures = 0;
  int num_checks = 0;
  typedef struct {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [1:0] br;
    logic [7:0] ra;
    logic [31:0] rd;
  } row_t;
  row_t rows[5];

  pwm_channel_waveform_core i_pwm_channel_waveform_core (.aclk(aclk), .aresetn(aresetn),
    .sel_tick(sel_tick), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .pwm_out(pwm_out));
  pwm_load i_pwm_load (.aclk(aclk), .aresetn(aresetn), .pwm_out(pwm_out),
    .high_len(high_len), .low_len(low_len));

  // Free running clock, 10 ns period
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata; rs = rresp;
    rready <= 1'b0;
  endtask : rd

  // Hang guard: whole run needs only a few hundred cycles
  initial begin
    #200000;
    failures++;
    summarize();
  end

  initial begin
    aresetn = 1'b0; sel_tick = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'hF;
    rows[0] = '{8'h04, 32'h000001FF, 2'h0, 8'h04, 32'h000000FF};
    rows[1] = '{8'h04, 32'h00000004, 2'h0, 8'h14, 32'h00000004};
    rows[2] = '{8'h08, 32'h00000001, 2'h0, 8'h18, 32'h00000001};
    rows[3] = '{8'h10, 32'h000000FF, 2'h0, 8'h14, 32'h00000004};
    rows[4] = '{8'h1C, 32'h00000055, 2'h2, 8'h08, 32'h00000001};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    // Idle level with zero duty and low start level
    `CHK(pwm_out, 1'b1)
    rd(8'h00, c1, r);
    `CHK(c1, 32'h0)
    // Disabled channel: writes land in active latches at once
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd, r);
      `CHK(r, rows[i].br)
      rd(rows[i].ra, c1, r);
      `CHK(c1, rows[i].rd)
      `CHK(r, 2'h0)
    end
    rd(8'h1C, c1, r);
    `CHK(r, 2'h2)
    `CHK(c1, 32'h0)
    // Left aligned, starts high: one high tick, three low
    wr(8'h00, 32'h3, r);
    repeat (30) @(posedge aclk);
    `CHK(high_len, 16'h0001)
    `CHK(low_len, 16'h0003)
    wr(8'h00, 32'h1, r);
    repeat (30) @(posedge aclk);
    `CHK(low_len, 16'h0001)
    `CHK(high_len, 16'h0003)
    // No ticks: counter frozen though enabled
    sel_tick <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(8'h0C, c1, r);
    repeat (5) @(posedge aclk);
    rd(8'h0C, c2, r);
    `CHK(c2, c1)
    wr(8'h0C, 32'hFF, r);
    rd(8'h0C, c1, r);
    `CHK(c1, 32'h0)
    // Deferred period, then forced in by a counter write
    wr(8'h04, 32'h8, r);
    rd(8'h14, c1, r);
    `CHK(c1, 32'h4)
    wr(8'h0C, 32'h0, r);
    rd(8'h14, c1, r);
    `CHK(c1, 32'h8)
    // Deferred duty, taken at period end
    wr(8'h08, 32'h3, r);
    rd(8'h18, c1, r);
    `CHK(c1, 32'h1)
    sel_tick <= 1'b1;
    repeat (20) @(posedge aclk);
    rd(8'h18, c1, r);
    `CHK(c1, 32'h3)
    // Disabled with ticks present: count holds
    wr(8'h00, 32'h0, r);
    rd(8'h0C, c1, r);
    repeat (5) @(posedge aclk);
    rd(8'h0C, c2, r);
    `CHK(c2, c1)
    // Center aligned: up to four and back, high only at zero
    wr(8'h04, 32'h4, r);
    wr(8'h08, 32'h1, r);
    wr(8'h00, 32'h7, r);
    repeat (40) @(posedge aclk);
    `CHK(high_len, 16'h0001)
    `CHK(low_len, 16'h0007)
    // Single ticks in center mode: up to four, then one step down
    sel_tick <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(8'h0C, 32'h0, r);
    repeat (5) begin
      @(posedge aclk);
      sel_tick <= 1'b1;
      @(posedge aclk);
      sel_tick <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    rd(8'h0C, c1, r);
    `CHK(c1, 32'h3)
    rd(8'h10, c2, r);
    `CHK(c2, 32'h2)
    `CHK(pwm_out, 1'b0)
    // Reset in mid-run: control and active values return to reset state
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(pwm_out, 1'b1)
    rd(8'h00, c1, r);
    `CHK(c1, 32'h0)
    rd(8'h14, c1, r);
    `CHK(c1, {24'h000000, pwm_pkg::PERIOD_RST})
    rd(8'h0C, c1, r);
    `CHK(c1, 32'h0)
    summarize();
  end
endmodule : testbench
`default_nettype wire
